// file: logic/io_space_defines.svh
// Purpose: Shared offsets, field positions, reset values and counts of the I/O space.
// Assumes: Included by the package and the design files by bare name.
// Notes: Definitions only.
`ifndef IO_SPACE_DEFINES_SVH
`define IO_SPACE_DEFINES_SVH

// --------
// Address space
// --------
`define IO_LOC_COUNT 64
`define IO_ADDR_W 6
`define IO_DATA_W 8
`define IO_DATA_OFFSET 7'h20
`define IO_DATA_TOP 7'h5F
`define IO_BIT_LIMIT 6'h1F
`define IO_MAPPED_TOP 6'h27
`define IO_RESET_VALUE 8'h00

// --------
// Register locations
// --------
`define IO_LOC_INPUT_DISABLE 6'h01
`define IO_LOC_BAUD_HIGH 6'h02
`define IO_LOC_FRAME_FORMAT 6'h03
`define IO_LOC_COMPARATOR 6'h08
`define IO_LOC_SERIAL_STATUS 6'h0B
`define IO_LOC_USI_STATUS 6'h0E
`define IO_LOC_PORT_D_IN 6'h10
`define IO_LOC_PORT_D_DIR 6'h11
`define IO_LOC_PORT_D_OUT 6'h12
`define IO_LOC_PORT_B_IN 6'h16
`define IO_LOC_PORT_A_IN 6'h19
`define IO_LOC_PORT_A_DIR 6'h1A
`define IO_LOC_PORT_A_OUT 6'h1B
`define IO_LOC_EE_CONTROL 6'h1C
`define IO_LOC_EE_ADDRESS 6'h1E
`define IO_LOC_WATCHDOG 6'h21
`define IO_LOC_FORCE_COMPARE 6'h22
`define IO_LOC_PRESCALER 6'h23
`define IO_LOC_CLOCK_DIV 6'h26

// --------
// Write-one-to-clear flag positions and event inputs
// --------
`define IO_CMP_FLAG_BIT 4
`define IO_TX_DONE_BIT 6
`define IO_USI_START_BIT 7
`define IO_USI_OVF_BIT 6
`define IO_USI_STOP_BIT 5
`define IO_WDOG_FLAG_BIT 7
`define IO_EVENT_COUNT 6

`endif

// file: logic/io_space_pkg.sv
// Purpose: Types and shared decode functions of the I/O register space.
// Assumes: io_space_defines.svh holds the numbers.
// Notes: Both ends use the same location masks.
`include "io_space_defines.svh"

package io_space_pkg;

  // --------
  // Types
  // --------
  // Operation carried to the register space
  typedef enum logic [4:0] {
    IO_OP_READ = 5'h01,
    IO_OP_WRITE = 5'h02,
    IO_OP_SET_BIT = 5'h04,
    IO_OP_CLR_BIT = 5'h08,
    IO_OP_TEST_BIT = 5'h10
  } io_op_t;

  // Instruction kinds accepted by the core-side end
  typedef enum logic [7:0] {
    CMD_IO_IN = 8'h01,
    CMD_IO_OUT = 8'h02,
    CMD_DATA_SPACE_LOAD_INSTR = 8'h04,
    CMD_DATA_SPACE_STORE_INSTR = 8'h08,
    CMD_SET_SINGLE_BIT_INSTR = 8'h10,
    CMD_CLEAR_SINGLE_BIT_INSTR = 8'h20,
    CMD_SKIP_IF_IO_BIT_SET_INSTR = 8'h40,
    CMD_SKIP_IF_IO_BIT_CLEAR_INSTR = 8'h80
  } cmd_t;

  // Core-side sequencer states
  typedef enum logic [1:0] {
    CORE_IDLE = 2'h1,
    CORE_WAIT = 2'h2
  } core_state_t;

  // --------
  // Decode functions
  // --------
  // Implemented bits of a location; zero marks reserved
  function automatic logic [7:0] loc_mask(input logic [5:0] loc);
    case (loc)
      `IO_LOC_INPUT_DISABLE: loc_mask = 8'h03;
      `IO_LOC_BAUD_HIGH: loc_mask = 8'h0F;
      `IO_LOC_FRAME_FORMAT: loc_mask = 8'h7F;
      6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F: loc_mask = 8'hFF;
      `IO_LOC_PORT_D_IN, `IO_LOC_PORT_D_DIR, `IO_LOC_PORT_D_OUT: loc_mask = 8'h7F;
      6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18: loc_mask = 8'hFF;
      `IO_LOC_PORT_A_IN, `IO_LOC_PORT_A_DIR, `IO_LOC_PORT_A_OUT: loc_mask = 8'h07;
      `IO_LOC_EE_CONTROL: loc_mask = 8'h3F;
      6'h1D: loc_mask = 8'hFF;
      `IO_LOC_EE_ADDRESS: loc_mask = 8'h7F;
      6'h20, `IO_LOC_WATCHDOG, 6'h24, 6'h25: loc_mask = 8'hFF;
      `IO_LOC_FORCE_COMPARE: loc_mask = 8'hC0;
      `IO_LOC_PRESCALER: loc_mask = 8'h01;
      `IO_LOC_CLOCK_DIV: loc_mask = 8'h8F;
      default: loc_mask = 8'h00;
    endcase
  endfunction

  // Reserved location inside the mapped lower part
  function automatic logic is_reserved(input logic [5:0] loc);
    is_reserved = (loc <= `IO_MAPPED_TOP) && (loc_mask(loc) == 8'h00);
  endfunction

endpackage

// file: logic/io_space_if.sv
// Purpose: Carrier between the core-side end and the register space.
// Assumes: One clock; requests held until answered.
// Notes: No clocking block; the bench joins both ends here.
`timescale 1ns/1ps
`default_nettype none

interface io_space_if;
  import io_space_pkg::*;

  // Request, held by the core end until ack
  logic req;
  io_op_t op;
  logic [5:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  // Answer; ack is a one-cycle pulse, data held until the next take
  logic ack;
  logic [7:0] rdata;
  logic bit_val;
  logic refused;

  // Core end issues requests
  modport core_end(output req, output op, output addr, output bit_sel, output wdata,
    input ack, input rdata, input bit_val, input refused);

  // Register space answers them
  modport regs_end(input req, input op, input addr, input bit_sel, input wdata,
    output ack, output rdata, output bit_val, output refused);
endinterface

`default_nettype wire

// file: logic/io_bit_merge.sv
// Purpose: Next value of one register location under a write.
// Assumes: Mask already limited to implemented, addressed bits.
// Notes: Flag bits clear on one and hold on zero.
`timescale 1ns/1ps
`default_nettype none

module io_bit_merge #(
  parameter int unsigned WIDTH = 8
) (
  // Current contents and write
  input wire logic [WIDTH-1:0] old_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [WIDTH-1:0] mask_in,
  input wire logic [WIDTH-1:0] clear_mask_in,
  // Merged value
  output logic [WIDTH-1:0] new_out
);

  // --------
  // Merge
  // --------
  // Plain bits take the data; flag bits drop where a one is written
  always_comb begin
    new_out = (old_in & ~mask_in)
      | (wdata_in & mask_in & ~clear_mask_in)
      | (old_in & mask_in & clear_mask_in & ~wdata_in);
  end

endmodule

`default_nettype wire

// file: logic/io_register_space.sv
// Purpose: The whole 64-location I/O register space, with bit access on the lower half.
// Assumes: The core end holds a request until ack; pins synchronous to clk_in.
// Notes: Locations above the mapped part read as zero here.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.svh"

module io_register_space #(
  parameter int unsigned IO_LOCS = `IO_LOC_COUNT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Core side
  io_space_if.regs_end bus,
  // Port pin levels
  input wire logic [7:0] pin_a_in,
  input wire logic [7:0] pin_b_in,
  input wire logic [7:0] pin_d_in,
  // Peripheral flag events, one per flag
  input wire logic [`IO_EVENT_COUNT-1:0] flag_event_in,
  // Contents of every location
  output logic [`IO_LOC_COUNT-1:0][7:0] io_image_out
);
  import io_space_pkg::*;

  // --------
  // Elaboration checks
  // --------
  // The decode covers exactly 64 locations
  if (IO_LOCS != `IO_LOC_COUNT) begin : g_bad_locs
    $error("io_register_space serves only 64 locations");
  end

  // --------
  // Decode helpers
  // --------
  // Used by storage; is_pin_loc also by request decode
  // Flag bits that clear on a written one
  function automatic logic [7:0] clear_mask(input logic [5:0] loc);
    case (loc)
      `IO_LOC_COMPARATOR: clear_mask = 8'h01 << `IO_CMP_FLAG_BIT;
      `IO_LOC_SERIAL_STATUS: clear_mask = 8'h01 << `IO_TX_DONE_BIT;
      `IO_LOC_USI_STATUS: clear_mask = (8'h01 << `IO_USI_START_BIT)
        | (8'h01 << `IO_USI_OVF_BIT) | (8'h01 << `IO_USI_STOP_BIT);
      `IO_LOC_WATCHDOG: clear_mask = 8'h01 << `IO_WDOG_FLAG_BIT;
      default: clear_mask = 8'h00;
    endcase
  endfunction

  // Flag bits raised by peripheral events at a location
  function automatic logic [7:0] event_bits(input logic [5:0] loc,
                                            input logic [`IO_EVENT_COUNT-1:0] ev);
    event_bits = 8'h00;
    case (loc)
      `IO_LOC_COMPARATOR: event_bits[`IO_CMP_FLAG_BIT] = ev[0];
      `IO_LOC_SERIAL_STATUS: event_bits[`IO_TX_DONE_BIT] = ev[1];
      `IO_LOC_USI_STATUS: begin
        event_bits[`IO_USI_START_BIT] = ev[2];
        event_bits[`IO_USI_OVF_BIT] = ev[3];
        event_bits[`IO_USI_STOP_BIT] = ev[4];
      end
      `IO_LOC_WATCHDOG: event_bits[`IO_WDOG_FLAG_BIT] = ev[5];
      default: event_bits = 8'h00;
    endcase
  endfunction

  // Locations that mirror pins and ignore writes
  function automatic logic is_pin_loc(input logic [5:0] loc);
    is_pin_loc = (loc == `IO_LOC_PORT_A_IN)
      || (loc == `IO_LOC_PORT_B_IN)
      || (loc == `IO_LOC_PORT_D_IN);
  endfunction

  // --------
  // Request decode
  // --------
  logic ack_r; // Answer pulse
  logic [7:0] rdata_r; // Read data of the answer
  logic bit_val_r; // Tested bit of the answer
  logic refused_r; // Bit access out of range
  logic [7:0] regs_r [`IO_LOC_COUNT]; // Location storage

  // Held request decode
  logic take; // Request accepted this cycle
  logic is_bit_op; // Set, clear or test
  logic bit_range_bad; // Bit access above the bit window
  logic do_write; // Request changes a location
  logic [7:0] bit_onehot; // Addressed bit
  logic [7:0] cur_val; // Visible value of the addressed location

  // A request is taken once; the held req is ignored while ack shows
  assign take = bus.req && !ack_r;
  assign is_bit_op = (bus.op == IO_OP_SET_BIT) || (bus.op == IO_OP_CLR_BIT)
    || (bus.op == IO_OP_TEST_BIT);
  // Refused, never wrapped low
  assign bit_range_bad = is_bit_op && (bus.addr > `IO_BIT_LIMIT);
  // Pin mirrors never take writes
  assign do_write = take && !bit_range_bad && !is_pin_loc(bus.addr)
    && ((bus.op == IO_OP_WRITE) || (bus.op == IO_OP_SET_BIT)
    || (bus.op == IO_OP_CLR_BIT));
  // Addressed bit as a mask
  assign bit_onehot = 8'h01 << bus.bit_sel;

  // Reserved bits and locations read back as zero
  assign cur_val = regs_r[bus.addr] & loc_mask(bus.addr);

  // --------
  // Location storage
  // --------
  // One byte and merge per location
  for (genvar i = 0; i < `IO_LOC_COUNT; i++) begin : g_loc
    localparam logic [5:0] LOC = 6'(i);
    logic hit; // This location is written now
    logic [7:0] wr_mask; // Bits the write may touch
    logic [7:0] wr_data; // Data presented to the merge
    logic [7:0] merged; // Value after the write
    logic [7:0] pin_src; // Pin levels for mirror locations

    assign hit = do_write && (bus.addr == LOC);
    // Full writes cover implemented bits; bit ops cover one bit
    assign wr_mask = (bus.op == IO_OP_WRITE) ? loc_mask(LOC)
      : (bit_onehot & loc_mask(LOC));
    // Set writes a one, clear writes a zero, into the addressed bit
    assign wr_data = (bus.op == IO_OP_WRITE) ? bus.wdata
      : ((bus.op == IO_OP_SET_BIT) ? bit_onehot : 8'h00);
    assign pin_src = (LOC == `IO_LOC_PORT_A_IN) ? pin_a_in
      : ((LOC == `IO_LOC_PORT_B_IN) ? pin_b_in : pin_d_in);

    // Writes and bit ops share one path
    io_bit_merge #(
      .WIDTH(8)
    ) u_merge (
      .old_in(regs_r[i]),
      .wdata_in(wr_data),
      .mask_in(wr_mask),
      .clear_mask_in(clear_mask(LOC)),
      .new_out(merged)
    );

    // Stores writes; a flag event in the same cycle wins over its clear
    always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
        regs_r[i] <= `IO_RESET_VALUE;
      end else if (is_pin_loc(LOC)) begin
        // Mirrors follow the pins
        regs_r[i] <= pin_src & loc_mask(LOC);
      end else if (hit) begin
        // Events OR in last, so set wins
        regs_r[i] <= merged
          | (event_bits(LOC, flag_event_in) & loc_mask(LOC));
      end else begin
        // Idle cycles collect events
        regs_r[i] <= regs_r[i]
          | (event_bits(LOC, flag_event_in) & loc_mask(LOC));
      end
    end
  end

  // --------
  // Answer
  // --------
  // One-cycle acknowledge for every taken request
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  // Read data and tested bit, captured with the request
  // Held until the next take for slow readers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_r <= 8'h00;
      bit_val_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (take) begin
      // Refused bit accesses return zero
      rdata_r <= bit_range_bad ? 8'h00 : cur_val;
      bit_val_r <= !bit_range_bad && cur_val[bus.bit_sel];
      refused_r <= bit_range_bad;
    end
  end

  // --------
  // Outputs
  // --------
  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;
  assign bus.bit_val = bit_val_r;
  assign bus.refused = refused_r;
  // Storage copied out byte by byte
  always_comb begin
    for (int j = 0; j < `IO_LOC_COUNT; j++) begin
      io_image_out[j] = regs_r[j];
    end
  end

endmodule

`default_nettype wire

// file: logic/io_core_port.sv
// Purpose: Core-side end that turns I/O and data-space instructions into requests.
// Assumes: One instruction at a time; cmd taken when ready shows.
// Notes: Illegal instructions finish at once with error and send nothing.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.svh"

module io_core_port (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Instruction side
  input wire logic cmd_valid_in,
  input wire io_space_pkg::cmd_t cmd_kind_in,
  input wire logic [6:0] cmd_addr_in,
  input wire logic [2:0] cmd_bit_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  // Results
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic skip_out,
  output logic error_out,
  // Register space
  io_space_if.core_end bus
);
  import io_space_pkg::*;

  // --------
  // Instruction decode
  // --------
  core_state_t state_r; // Sequencer state
  logic req_r; // Request held until ack
  io_op_t op_r; // Operation sent
  logic [5:0] addr_r; // I/O location sent
  logic [2:0] bit_r; // Bit sent
  logic [7:0] wdata_r; // Write data sent
  logic skip_clr_r; // Skip on a cleared bit
  logic ready_r, done_r, skip_r, error_r;
  logic [7:0] rdata_r;
  logic is_data_space, is_write, is_bit_op, bad;
  logic [6:0] io_addr_wide;
  logic [5:0] io_addr;
  io_op_t op_nxt;

  assign is_data_space = (cmd_kind_in == CMD_DATA_SPACE_LOAD_INSTR)
    || (cmd_kind_in == CMD_DATA_SPACE_STORE_INSTR);
  assign is_write = (cmd_kind_in == CMD_IO_OUT) || (cmd_kind_in == CMD_DATA_SPACE_STORE_INSTR)
    || (cmd_kind_in == CMD_SET_SINGLE_BIT_INSTR) || (cmd_kind_in == CMD_CLEAR_SINGLE_BIT_INSTR);
  assign is_bit_op = (cmd_kind_in == CMD_SET_SINGLE_BIT_INSTR)
    || (cmd_kind_in == CMD_CLEAR_SINGLE_BIT_INSTR)
    || (cmd_kind_in == CMD_SKIP_IF_IO_BIT_SET_INSTR)
    || (cmd_kind_in == CMD_SKIP_IF_IO_BIT_CLEAR_INSTR);
  // Data-space addresses sit 0x20 above the I/O address
  assign io_addr_wide = is_data_space ? (cmd_addr_in - `IO_DATA_OFFSET) : cmd_addr_in;
  assign io_addr = io_addr_wide[5:0];

  // Refuse out-of-window addresses, high bit ops and reserved writes
  always_comb begin
    bad = 1'b0;
    if (is_data_space) begin
      bad = (cmd_addr_in < `IO_DATA_OFFSET) || (cmd_addr_in > `IO_DATA_TOP);
    end else if (cmd_addr_in[6]) begin
      bad = 1'b1;
    end
    if (is_bit_op && (io_addr > `IO_BIT_LIMIT)) begin
      bad = 1'b1;
    end
    if (is_write && is_reserved(io_addr)) begin
      bad = 1'b1;
    end
  end

  // Operation for each instruction kind
  always_comb begin
    case (cmd_kind_in)
      CMD_IO_OUT, CMD_DATA_SPACE_STORE_INSTR: op_nxt = IO_OP_WRITE;
      CMD_SET_SINGLE_BIT_INSTR: op_nxt = IO_OP_SET_BIT;
      CMD_CLEAR_SINGLE_BIT_INSTR: op_nxt = IO_OP_CLR_BIT;
      CMD_SKIP_IF_IO_BIT_SET_INSTR, CMD_SKIP_IF_IO_BIT_CLEAR_INSTR: op_nxt = IO_OP_TEST_BIT;
      default: op_nxt = IO_OP_READ;
    endcase
  end

  // --------
  // Sequencer
  // --------
  // Launch one request and wait for its answer
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_r <= CORE_IDLE;
      req_r <= 1'b0;
      op_r <= IO_OP_READ;
      addr_r <= 6'h00;
      bit_r <= 3'h0;
      wdata_r <= 8'h00;
      skip_clr_r <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      case (state_r)
        CORE_IDLE: begin
          if (cmd_valid_in && !bad) begin
            state_r <= CORE_WAIT;
            req_r <= 1'b1;
            op_r <= op_nxt;
            addr_r <= io_addr;
            bit_r <= cmd_bit_in;
            // Reserved bit positions of mapped locations go out as zero; above 0x27 data goes out unmasked
            wdata_r <= (io_addr <= `IO_MAPPED_TOP) ?
              (cmd_data_in & loc_mask(io_addr)) : cmd_data_in;
            skip_clr_r <= (cmd_kind_in == CMD_SKIP_IF_IO_BIT_CLEAR_INSTR);
            ready_r <= 1'b0;
          end
        end
        CORE_WAIT: begin
          if (bus.ack) begin
            state_r <= CORE_IDLE;
            req_r <= 1'b0;
            ready_r <= 1'b1;
          end
        end
        default: begin
          state_r <= CORE_IDLE;
          req_r <= 1'b0;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  // Results, one-cycle done pulse
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      skip_r <= 1'b0;
      error_r <= 1'b0;
    end else if ((state_r == CORE_IDLE) && cmd_valid_in && bad) begin
      done_r <= 1'b1;
      rdata_r <= 8'h00;
      skip_r <= 1'b0;
      error_r <= 1'b1;
    end else if ((state_r == CORE_WAIT) && bus.ack) begin
      done_r <= 1'b1;
      rdata_r <= bus.rdata;
      skip_r <= (op_r == IO_OP_TEST_BIT) && !bus.refused
        && (bus.bit_val ^ skip_clr_r);
      error_r <= bus.refused;
    end else begin
      done_r <= 1'b0;
    end
  end

  // --------
  // Outputs
  // --------
  assign bus.req = req_r;
  assign bus.op = op_r;
  assign bus.addr = addr_r;
  assign bus.bit_sel = bit_r;
  assign bus.wdata = wdata_r;
  assign cmd_ready_out = ready_r;
  assign done_out = done_r;
  assign rdata_out = rdata_r;
  assign skip_out = skip_r;
  assign error_out = error_r;

endmodule

`default_nettype wire

// file: bench/io_space_sva.sv
// Purpose: Protocol and decode checks on the core-to-register carrier.
// Assumes: Signals taken straight from the joining interface; one clock.
// Notes: Bit-op refusal is judged on the second carrier by the bench.
`timescale 1ns/1ps
`default_nettype none

module io_space_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Request
  input wire logic req,
  input wire io_space_pkg::io_op_t op,
  input wire logic [5:0] addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  // Answer
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic bit_val,
  input wire logic refused
);
  import io_space_pkg::*;
  // --------
  // Helpers
  // --------
  // Request taken at this edge
  wire logic take = req && !ack;
  // Bit operation kinds
  wire logic bit_op = (op == IO_OP_SET_BIT) || (op == IO_OP_CLR_BIT) || (op == IO_OP_TEST_BIT);
  // Locations that must never be written
  wire logic resv = addr inside {6'h00, 6'h04, 6'h05, 6'h06, 6'h07, 6'h1F, 6'h27};
  // Write kinds
  wire logic wr_op = (op == IO_OP_WRITE) || (op == IO_OP_SET_BIT) || (op == IO_OP_CLR_BIT);

  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // --------
  // Properties
  // --------
  property p_answer;
    take |=> ack;
  endproperty
  a_answer: assert property (p_answer) else $error("no ack after take");
  property p_ack_pulse;
    ack |=> !ack && !req;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack or req stuck");
  property p_hold;
    take |=> req && $stable(addr) && $stable(op) && $stable(wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed early");
  property p_hold_answer;
    ack |=> $stable(rdata) && $stable(refused) && $stable(bit_val);
  endproperty
  a_hold_answer: assert property (p_hold_answer) else $error("answer not held");
  property p_bit_accept;
    take && bit_op && (addr <= 6'h1F) |=> !refused;
  endproperty
  a_bit_accept: assert property (p_bit_accept) else $error("bit op refused low");
  property p_test_val;
    take && (op == IO_OP_TEST_BIT) |=> bit_val == rdata[bit_sel];
  endproperty
  a_test_val: assert property (p_test_val) else $error("bit test wrong value");
  property p_res_read;
    take && (op == IO_OP_READ) && (resv || addr > 6'h27) |=> rdata == 8'h00;
  endproperty
  a_res_read: assert property (p_res_read) else $error("reserved read not zero");
  property p_no_res_write;
    req && wr_op |-> !resv;
  endproperty
  a_no_res_write: assert property (p_no_res_write) else $error("reserved written");
  property p_res_bits;
    req && (op == IO_OP_WRITE) && (addr == 6'h1B) |-> wdata[7:3] == 5'h00;
  endproperty
  a_res_bits: assert property (p_res_bits) else $error("reserved bits nonzero");

  // Main scenarios
  c_write: cover property (take && op == IO_OP_WRITE);
  c_test: cover property (take && op == IO_OP_TEST_BIT);
  c_set: cover property (take && op == IO_OP_SET_BIT);
endmodule

`default_nettype wire

// file: bench/io_register_space_decoder_tb.sv
// Purpose: Self-checking bench for the core end and register space.
// Assumes: Both ends joined; a second space faces a rule-breaking driver.
// Notes: Expected values come from the location masks and flag positions.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.svh"

module io_register_space_decoder_tb;
  import io_space_pkg::*;
  // --------
  // Signals
  // --------
  logic clk_in, rst_b_in, cmd_valid, cmd_ready, done, skip, error;
  cmd_t cmd_kind;
  logic [6:0] cmd_addr;
  logic [2:0] cmd_bit;
  logic [7:0] cmd_data, rdata, pin_a, pin_b, pin_d, got;
  logic [5:0] events;
  logic [`IO_LOC_COUNT-1:0][7:0] image, image_b;
  logic got_skip, got_err, got_ref;
  int miscompares, checks, cycles;

  io_space_if bus_if();
  io_space_if bus_b_if();
  io_register_space io_register_space_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(bus_if),
    .pin_a_in(pin_a), .pin_b_in(pin_b), .pin_d_in(pin_d), .flag_event_in(events),
    .io_image_out(image));
  // Second space, driven raw to break core-side rules
  io_register_space io_register_space_b_i(.clk_in(clk_in), .rst_b_in(rst_b_in),
    .bus(bus_b_if), .pin_a_in(8'h00), .pin_b_in(8'h00), .pin_d_in(8'h00),
    .flag_event_in(6'h00), .io_image_out(image_b));
  io_core_port io_core_port_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid),
    .cmd_kind_in(cmd_kind), .cmd_addr_in(cmd_addr), .cmd_bit_in(cmd_bit),
    .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .done_out(done), .rdata_out(rdata),
    .skip_out(skip), .error_out(error), .bus(bus_if));
  io_space_sva io_space_sva_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .req(bus_if.req),
    .op(bus_if.op), .addr(bus_if.addr), .bit_sel(bus_if.bit_sel), .wdata(bus_if.wdata),
    .ack(bus_if.ack), .rdata(bus_if.rdata), .bit_val(bus_if.bit_val),
    .refused(bus_if.refused));

  // --------
  // Helpers
  // --------
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  // One instruction through the core end, waiting for done
  task automatic do_cmd(input cmd_t k, input logic [6:0] a, input logic [2:0] b,
    input logic [7:0] d);
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_bit <= b;
    cmd_data <= d;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    #1;
    for (int i = 0; i < 8 && done !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    chk_bit(done, 1'b1);
    chk_bit(cmd_ready, 1'b1);
    got = rdata;
    got_skip = skip;
    got_err = error;
  endtask
  // One raw carrier transfer on the second space
  task automatic raw(input io_op_t o, input logic [5:0] a, input logic [2:0] b,
    input logic [7:0] d);
    @(posedge clk_in);
    bus_b_if.req <= 1'b1;
    bus_b_if.op <= o;
    bus_b_if.addr <= a;
    bus_b_if.bit_sel <= b;
    bus_b_if.wdata <= d;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      #1;
      if (bus_b_if.ack === 1'b1) break;
    end
    got = bus_b_if.rdata;
    got_ref = bus_b_if.refused;
    @(posedge clk_in);
    bus_b_if.req <= 1'b0;
  endtask
  task automatic pulse(input int n);
    @(posedge clk_in);
    events[n] <= 1'b1;
    @(posedge clk_in);
    events <= 6'h00;
    #1;
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_map;
    do_cmd(CMD_IO_OUT, 7'h13, 3'h0, 8'hA5);
    chk_byte(image[6'h13], 8'hA5);
    do_cmd(CMD_DATA_SPACE_LOAD_INSTR, 7'h33, 3'h0, 8'h00);
    chk_byte(got, 8'hA5);
    do_cmd(CMD_DATA_SPACE_STORE_INSTR, 7'h34, 3'h0, 8'h3C);
    chk_byte(image[6'h14], 8'h3C);
    do_cmd(CMD_IO_IN, 7'h14, 3'h0, 8'h00);
    chk_byte(got, 8'h3C);
    do_cmd(CMD_DATA_SPACE_LOAD_INSTR, 7'h36, 3'h0, 8'h00);
    chk_byte(got, 8'h5A);
    do_cmd(CMD_IO_IN, 7'h10, 3'h0, 8'h00);
    chk_byte(got, 8'h7F);
    do_cmd(CMD_DATA_SPACE_LOAD_INSTR, 7'h1F, 3'h0, 8'h00);
    chk_bit(got_err, 1'b1);
    do_cmd(CMD_DATA_SPACE_LOAD_INSTR, 7'h60, 3'h0, 8'h00);
    chk_bit(got_err, 1'b1);
    do_cmd(CMD_DATA_SPACE_LOAD_INSTR, 7'h5F, 3'h0, 8'h00);
    chk_bit(got_err, 1'b0);
    do_cmd(CMD_IO_IN, 7'h40, 3'h0, 8'h00);
    chk_bit(got_err, 1'b1);
  endtask
  task automatic t_bits;
    do_cmd(CMD_IO_OUT, 7'h15, 3'h0, 8'h00);
    for (int b = 0; b < 8; b++) begin
      do_cmd(CMD_SET_SINGLE_BIT_INSTR, 7'h15, b[2:0], 8'h00);
      chk_byte(image[6'h15], 8'hFF >> (7 - b));
      do_cmd(CMD_SKIP_IF_IO_BIT_SET_INSTR, 7'h15, b[2:0], 8'h00);
      chk_bit(got_skip, 1'b1);
    end
    do_cmd(CMD_CLEAR_SINGLE_BIT_INSTR, 7'h15, 3'h3, 8'h00);
    chk_byte(image[6'h15], 8'hF7);
    do_cmd(CMD_SKIP_IF_IO_BIT_CLEAR_INSTR, 7'h15, 3'h3, 8'h00);
    chk_bit(got_skip, 1'b1);
    do_cmd(CMD_SKIP_IF_IO_BIT_CLEAR_INSTR, 7'h15, 3'h4, 8'h00);
    chk_bit(got_skip, 1'b0);
    do_cmd(CMD_SET_SINGLE_BIT_INSTR, 7'h20, 3'h0, 8'h00);
    chk_bit(got_err, 1'b1);
    chk_byte(image[6'h20], 8'h00);
  endtask
  task automatic t_flags;
    pulse(2);
    pulse(3);
    chk_byte(image[6'h0E], 8'hC0);
    do_cmd(CMD_IO_OUT, 7'h0E, 3'h0, 8'h85);
    chk_byte(image[6'h0E], 8'h45);
    do_cmd(CMD_SET_SINGLE_BIT_INSTR, 7'h0E, 3'h1, 8'h00);
    chk_byte(image[6'h0E], 8'h47);
    do_cmd(CMD_CLEAR_SINGLE_BIT_INSTR, 7'h0E, 3'h6, 8'h00);
    chk_byte(image[6'h0E], 8'h47);
    do_cmd(CMD_SET_SINGLE_BIT_INSTR, 7'h0E, 3'h6, 8'h00);
    chk_byte(image[6'h0E], 8'h07);
    pulse(0);
    do_cmd(CMD_SKIP_IF_IO_BIT_SET_INSTR, 7'h08, 3'h4, 8'h00);
    chk_bit(got_skip, 1'b1);
    do_cmd(CMD_IO_OUT, 7'h08, 3'h0, 8'h00);
    chk_byte(image[6'h08], 8'h10);
    pulse(5);
    chk_byte(image[6'h21], 8'h80);
  endtask
  task automatic t_reserved;
    do_cmd(CMD_IO_OUT, 7'h1B, 3'h0, 8'hFF);
    chk_byte(image[6'h1B], 8'h07);
    do_cmd(CMD_IO_IN, 7'h05, 3'h0, 8'h00);
    chk_byte(got, 8'h00);
    do_cmd(CMD_IO_OUT, 7'h06, 3'h0, 8'hFF);
    chk_bit(got_err, 1'b1);
    do_cmd(CMD_IO_IN, 7'h19, 3'h0, 8'h00);
    chk_byte(got, 8'h05);
    raw(IO_OP_WRITE, 6'h27, 3'h0, 8'hFF);
    chk_byte(image_b[6'h27], 8'h00);
    raw(IO_OP_WRITE, 6'h05, 3'h0, 8'hFF);
    raw(IO_OP_READ, 6'h05, 3'h0, 8'h00);
    chk_byte(got, 8'h00);
    raw(IO_OP_WRITE, 6'h1B, 3'h0, 8'hFF);
    chk_byte(image_b[6'h1B], 8'h07);
    raw(IO_OP_SET_BIT, 6'h20, 3'h0, 8'h00);
    chk_bit(got_ref, 1'b1);
    chk_byte(image_b[6'h20], 8'h00);
    raw(IO_OP_TEST_BIT, 6'h25, 3'h1, 8'h00);
    chk_bit(got_ref, 1'b1);
  endtask

  // --------
  // Clock, timeout and main sequence
  // --------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Cuts a hang short well past the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    rst_b_in = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = CMD_IO_IN;
    cmd_addr = 7'h00;
    cmd_bit = 3'h0;
    cmd_data = 8'h00;
    pin_a = 8'h05;
    pin_b = 8'h5A;
    pin_d = 8'hFF;
    events = 6'h00;
    bus_b_if.req = 1'b0;
    bus_b_if.op = IO_OP_READ;
    bus_b_if.addr = 6'h00;
    bus_b_if.bit_sel = 3'h0;
    bus_b_if.wdata = 8'h00;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_map();
    t_bits();
    t_flags();
    t_reserved();
    give_verdict();
  end
endmodule

`default_nettype wire
